/* design/aag_input_align.sv */
`timescale 1ns/1ns
// What this block does
// - Input data runs through a delay line of 144 selectable taps.
// - Aligner searches for a clean sampling point, then tracks drift.
// - Window slides along the line using only observed data transitions.
// - Acquisition window width is a user setting.
// - Dynamic control chooses continuous adjustment or a held delay.
// - Aligner works for single and double data rate capture.
// - Delay source: adaptive per bit, bus value, or static per bit.
// - Each cell supports DDR capture and a 2-bit shift.
// - Each cell also forms a 4-bit shift when the gear is set to x4.
// - Adaptive aligner present only in cells A and C.
// - Shift block hands data from fast domain to slow domain automatically.
module aag_input_align
  import aag_pkg::*;
#(
  parameter bit          HAS_ALIGNER = 1'b1,
  parameter int unsigned TAPS        = TAP_COUNT,
  parameter int unsigned DEPTH       = FIFO_DEPTH
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_pin,
  input  wire logic        i_pin_pair,
  input  wire aag_cfg_s    i_cfg,
  input  wire logic        i_word_ready,
  output logic [3:0]       o_word,
  output logic             o_word_valid,
  output logic             o_update,
  output aag_stat_s        o_stat,
  output logic             o_overrun
);
  initial begin
    if (TAPS != TAP_COUNT) begin
      $error("aag_input_align supports exactly the documented tap count");
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and delay line
  // ----------------------------------------------------------------
  logic [2:0]        sync_reg;
  logic [2:0]        sync_next;
  logic [2:0]        syncp_reg;
  logic [2:0]        syncp_next;
  logic [TAPS-1:0]   line_reg;
  logic [TAPS-1:0]   line_next;
  logic              pin_s;
  logic              pin_p;
  logic              pair_reg;
  logic              pair_next;

  // Three-stage synchronisers; a change counts once stages two and three agree
  always_comb begin
    sync_next  = {sync_reg[1:0], i_pin};
    syncp_next = {syncp_reg[1:0], i_pin_pair};
    pin_s      = (sync_reg[2] == sync_reg[1]) ? sync_reg[2] : line_reg[0];
    pin_p      = (syncp_reg[2] == syncp_reg[1]) ? syncp_reg[2] : pair_reg;
    pair_next  = pin_p;
    line_next  = {line_reg[TAPS-2:0], pin_s};
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sync_reg  <= '0;
      syncp_reg <= '0;
      pair_reg  <= 1'b0;
      line_reg  <= '0;
    end else begin
      sync_reg  <= sync_next;
      syncp_reg <= syncp_next;
      pair_reg  <= pair_next;
      line_reg  <= line_next;
    end
  end

  // ----------------------------------------------------------------
  // Adaptive aligner
  // ----------------------------------------------------------------
  aag_align_e       st_reg;
  aag_align_e       st_next;
  logic [TAP_W-1:0] tap_reg;
  logic [TAP_W-1:0] tap_next;
  logic [TAP_W-1:0] edge_tap_reg;
  logic [TAP_W-1:0] edge_tap_next;
  logic [TAP_W-1:0] sel_tap;
  logic [TAP_W-1:0] win_hi;
  logic             edge_in_win;
  logic             locked_reg;
  logic             locked_next;

  // Two taps per clock outrun the one-tap-per-clock flow of the line, so an edge leaves the window
  localparam logic [TAP_W-1:0] TAP_STEP = 8'h02;

  // Edge seen anywhere inside the window ahead of the current tap
  always_comb begin
    win_hi      = tap_reg + TAP_W'(i_cfg.win);
    if (win_hi > TAP_LAST) begin
      win_hi = TAP_LAST;
    end
    edge_in_win = 1'b0;
    for (int i = 0; i < int'(TAPS) - 1; i++) begin
      if (i >= int'(tap_reg) && i < int'(win_hi) && line_reg[i] != line_reg[i+1]) begin
        edge_in_win = 1'b1;
      end
    end
  end

  // Search, centre and track; hold freezes the tap
  always_comb begin
    st_next       = st_reg;
    tap_next      = tap_reg;
    edge_tap_next = edge_tap_reg;
    locked_next   = locked_reg;
    if (!HAS_ALIGNER || i_cfg.dly_mode != AAG_DLY_ADAPTIVE) begin
      st_next     = AAG_SEARCH;
      locked_next = 1'b0;
    end else if (i_cfg.hold) begin
      st_next = st_reg;
    end else begin
      unique case (st_reg)
        AAG_SEARCH: begin
          if (edge_in_win) begin
            tap_next = (tap_reg > TAP_LAST - TAP_STEP) ? TAP_RESET : tap_reg + TAP_STEP;
          end else begin
            edge_tap_next = tap_reg;
            st_next       = AAG_CENTER;
          end
        end
        AAG_CENTER: begin
          tap_next    = edge_tap_reg + TAP_W'(i_cfg.win >> 1);
          if (tap_next > TAP_LAST) begin
            tap_next = TAP_LAST;
          end
          locked_next = 1'b1;
          st_next     = AAG_TRACK;
        end
        AAG_TRACK: begin
          if (edge_in_win) begin
            // Move away from the edge to follow drift
            tap_next = (tap_reg > TAP_LAST - TAP_STEP) ? TAP_RESET : tap_reg + TAP_STEP;
            if (tap_reg - edge_tap_reg > TRACK_SPAN) begin
              locked_next = 1'b0;
              st_next     = AAG_SEARCH;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_reg       <= AAG_SEARCH;
      tap_reg      <= TAP_RESET;
      edge_tap_reg <= TAP_RESET;
      locked_reg   <= 1'b0;
    end else begin
      st_reg       <= st_next;
      tap_reg      <= tap_next;
      edge_tap_reg <= edge_tap_next;
      locked_reg   <= locked_next;
    end
  end

  // Tap source selection
  always_comb begin
    unique case (i_cfg.dly_mode)
      AAG_DLY_BUS:    sel_tap = i_cfg.bus_tap;
      AAG_DLY_STATIC: sel_tap = i_cfg.static_tap;
      default:        sel_tap = HAS_ALIGNER ? tap_reg : i_cfg.static_tap;
    endcase
    if (sel_tap > TAP_LAST) begin
      sel_tap = TAP_LAST;
    end
  end

  // ----------------------------------------------------------------
  // DDR capture and shift gearbox
  // ----------------------------------------------------------------
  logic       smp;
  logic [3:0] sh_reg;
  logic [3:0] sh_next;
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic       upd;

  // SDR takes one bit per clock; DDR takes the delayed bit and the pair bit
  always_comb begin
    smp        = line_reg[sel_tap];
    sh_next    = sh_reg;
    cnt_next   = cnt_reg;
    upd        = 1'b0;
    if (i_cfg.ddr_en) begin
      sh_next  = {sh_reg[1:0], smp, pin_p};
      cnt_next = cnt_reg + 2'h2;
    end else begin
      sh_next  = {sh_reg[2:0], smp};
      cnt_next = cnt_reg + 2'h1;
    end
    if (i_cfg.gear == AAG_GEAR_X4) begin
      upd = (cnt_next == 2'h0);
    end else begin
      upd = cnt_next[0] == 1'b0;
      cnt_next = {1'b0, cnt_next[0]};
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sh_reg    <= '0;
      cnt_reg   <= '0;
    end else begin
      sh_reg    <= sh_next;
      cnt_reg   <= cnt_next;
    end
  end

  // ----------------------------------------------------------------
  // Hand-off buffer to the slow domain
  // ----------------------------------------------------------------
  logic [3:0] f_word;
  logic       f_valid;
  logic       f_in_ready;
  logic [3:0] word_in;

  assign word_in = (i_cfg.gear == AAG_GEAR_X4) ? sh_next : {2'h0, sh_next[1:0]};

  aag_fifo #(
    .WIDTH (4),
    .DEPTH (DEPTH)
  ) u_fifo (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_data  (word_in),
    .i_valid (upd),
    .o_ready (f_in_ready),
    .o_data  (f_word),
    .o_valid (f_valid),
    .i_ready (i_word_ready)
  );

  // Registered outputs
  logic             upd_reg;
  logic             ovr_reg;
  logic [3:0]       word_reg;
  logic             wv_reg;
  logic [TAP_W-1:0] tapo_reg;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      upd_reg  <= 1'b0;
      ovr_reg  <= 1'b0;
      word_reg <= '0;
      wv_reg   <= 1'b0;
      tapo_reg <= TAP_RESET;
    end else begin
      upd_reg  <= upd;
      ovr_reg  <= ovr_reg || (upd && !f_in_ready);
      if (f_valid && i_word_ready) begin
        word_reg <= f_word;                              // Word stands until the next pop
      end
      wv_reg   <= f_valid && i_word_ready;
      tapo_reg <= sel_tap;
    end
  end

  always_comb begin
    o_word       = word_reg;
    o_word_valid = wv_reg;
    o_update     = upd_reg;
    o_overrun    = ovr_reg;
    o_stat       = '{locked: locked_reg, tap: tapo_reg};
  end

  chk_update_x2_rate : assert property (@(posedge i_clk) disable iff (i_rst)
    (i_cfg.gear == AAG_GEAR_X2 && !i_cfg.ddr_en && upd) ##1
    (i_cfg.gear == AAG_GEAR_X2 && !i_cfg.ddr_en) |-> !upd)
    else $error("x2 update strobe repeated on consecutive cycles");

  chk_hold_freezes_tap : assert property (@(posedge i_clk) disable iff (i_rst)
    i_cfg.hold && i_cfg.dly_mode == AAG_DLY_ADAPTIVE |=> tap_reg == $past(tap_reg))
    else $error("tap moved while held");

  chk_tap_in_range : assert property (@(posedge i_clk) disable iff (i_rst)
    sel_tap <= TAP_LAST && tap_reg <= TAP_LAST)
    else $error("selected tap beyond the delay line");

  chk_static_select : assert property (@(posedge i_clk) disable iff (i_rst)
    i_cfg.dly_mode == AAG_DLY_STATIC && i_cfg.static_tap <= TAP_LAST
    |-> sel_tap == i_cfg.static_tap)
    else $error("static tap not applied");

  chk_center_locks : assert property (@(posedge i_clk) disable iff (i_rst)
    st_reg == AAG_CENTER && !i_cfg.hold && i_cfg.dly_mode == AAG_DLY_ADAPTIVE
    |=> locked_reg && st_reg == AAG_TRACK)
    else $error("aligner did not lock after centring");

  chk_no_aligner : assert property (@(posedge i_clk) disable iff (i_rst)
    !HAS_ALIGNER |-> !locked_reg)
    else $error("lock reported in a cell without aligner");

  chk_update_pulse : assert property (@(posedge i_clk) disable iff (i_rst)
    upd |=> o_update)
    else $error("update strobe not presented");

  chk_search_moves : assert property (@(posedge i_clk) disable iff (i_rst)
    st_reg == AAG_SEARCH && edge_in_win && !i_cfg.hold
    && i_cfg.dly_mode == AAG_DLY_ADAPTIVE && HAS_ALIGNER
    |=> tap_reg != $past(tap_reg))
    else $error("window did not slide on a transition");

endmodule

/* design/aag_pkg.sv */
package aag_pkg;

  // ----------------------------------------------------------------
  // Delay line and aligner constants
  // ----------------------------------------------------------------
  localparam int unsigned TAP_COUNT     = 144;
  localparam int unsigned TAP_W         = 8;
  localparam logic [7:0]  TAP_LAST      = 8'h8F;
  localparam logic [7:0]  TAP_RESET     = 8'h00;
  localparam int unsigned WIN_W         = 4;
  localparam logic [3:0]  WIN_DEFAULT   = 4'h4;
  localparam logic [7:0]  TRACK_SPAN    = 8'h20;
  localparam int unsigned FIFO_DEPTH    = 8;

  // ----------------------------------------------------------------
  // Mode encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    AAG_DLY_ADAPTIVE = 2'h0,
    AAG_DLY_BUS      = 2'h1,
    AAG_DLY_STATIC   = 2'h2
  } aag_dly_mode_e;

  typedef enum logic {
    AAG_GEAR_X2 = 1'h0,
    AAG_GEAR_X4 = 1'h1
  } aag_gear_e;

  // Aligner states
  typedef enum logic [1:0] {
    AAG_SEARCH,
    AAG_CENTER,
    AAG_TRACK
  } aag_align_e;

  // Configuration bundle
  typedef struct packed {
    aag_dly_mode_e dly_mode;
    aag_gear_e     gear;
    logic          ddr_en;
    logic          hold;
    logic [3:0]    win;
    logic [7:0]    static_tap;
    logic [7:0]    bus_tap;
  } aag_cfg_s;

  // Status bundle
  typedef struct packed {
    logic       locked;
    logic [7:0] tap;
  } aag_stat_s;

endpackage

/* design/aag_fifo.sv */
`timescale 1ns/1ns
module aag_fifo
  import aag_pkg::*;
#(
  parameter int unsigned WIDTH = 4,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_data,
  input  wire logic             i_valid,
  output logic                  o_ready,
  output logic [WIDTH-1:0]      o_data,
  output logic                  o_valid,
  input  wire logic             i_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("aag_fifo depth must be a power of two, at least 2");
    end
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wr_reg;
  logic [AW:0]      wr_next;
  logic [AW:0]      rd_reg;
  logic [AW:0]      rd_next;
  logic             push;
  logic             pop;

  // ----------------------------------------------------------------
  // Pointer control
  // ----------------------------------------------------------------
  always_comb begin
    o_valid = (wr_reg != rd_reg);
    o_ready = (wr_reg[AW-1:0] != rd_reg[AW-1:0]) || (wr_reg[AW] == rd_reg[AW]);
    o_data  = mem_reg[rd_reg[AW-1:0]];
    push    = i_valid && o_ready;
    pop     = o_valid && i_ready;
    wr_next = wr_reg + (AW+1)'(push);
    rd_next = rd_reg + (AW+1)'(pop);
  end

  // Storage and pointer registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
    end
    if (push) begin
      mem_reg[wr_reg[AW-1:0]] <= i_data;
    end
  end

  chk_fifo_no_overflow : assert property (@(posedge i_clk) disable iff (i_rst)
    (!o_ready) |-> (wr_reg - rd_reg) == (AW+1)'(DEPTH))
    else $error("FIFO refused data while not full");

endmodule

/* dv/aag_tx_model.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Serial transmitter that drives the pin from outside the cell
// ----------------------------------------------------------------
module aag_tx_model #(
  parameter int unsigned BIT_CYCLES = 16
) (
  input  wire logic       i_clk,
  input  wire logic       i_pat,
  input  wire logic [1:0] i_lvl,
  output logic            o_pin,
  output logic            o_pin_pair
);
  logic [6:0]  lfsr_reg = 7'h01;
  int unsigned div_cnt  = 0;

  // Seven-bit sequence gives data edges but no training pattern;
  // each bit stands several clocks so the delay line holds clean stretches
  always @(negedge i_clk) begin
    if (div_cnt == BIT_CYCLES - 1) begin
      div_cnt  <= 0;
      lfsr_reg <= {lfsr_reg[5:0], lfsr_reg[6] ^ lfsr_reg[5]};
    end else begin
      div_cnt <= div_cnt + 1;
    end
  end

  // Pattern 0 holds fixed levels, pattern 1 sends the sequence
  assign o_pin      = i_pat ? lfsr_reg[0] : i_lvl[1];
  assign o_pin_pair = i_pat ? lfsr_reg[3] : i_lvl[0];
endmodule

/* dv/tb.sv */
`timescale 1ns/1ns
module tb;
  import aag_pkg::*;
  logic       i_clk;
  logic       i_rst;
  logic       i_word_ready;
  logic       pat;
  logic [1:0] lvl;
  logic       pin;
  logic       pin_pair;
  aag_cfg_s   cfg;
  logic [3:0] o_word;
  logic       o_word_valid;
  logic       o_update;
  logic       o_overrun;
  aag_stat_s  o_stat;
  aag_stat_s  b_stat;
  logic [7:0] tap_seen;
  int         failures;
  int         samples_checked;

  // ----------------------------------------------------------------
  // Clock, transmitter and device
  // ----------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  aag_tx_model tx (
    .i_clk      (i_clk),
    .i_pat      (pat),
    .i_lvl      (lvl),
    .o_pin      (pin),
    .o_pin_pair (pin_pair)
  );

  aag_input_align uut (
    .i_clk        (i_clk),
    .i_rst        (i_rst),
    .i_pin        (pin),
    .i_pin_pair   (pin_pair),
    .i_cfg        (cfg),
    .i_word_ready (i_word_ready),
    .o_word       (o_word),
    .o_word_valid (o_word_valid),
    .o_update     (o_update),
    .o_stat       (o_stat),
    .o_overrun    (o_overrun)
  );

  // Cell without aligner, as in cells B and D
  aag_input_align #(
    .HAS_ALIGNER (1'b0)
  ) uut_b (
    .i_clk        (i_clk),
    .i_rst        (i_rst),
    .i_pin        (pin),
    .i_pin_pair   (pin_pair),
    .i_cfg        (cfg),
    .i_word_ready (i_word_ready),
    .o_word       (),
    .o_word_valid (),
    .o_update     (),
    .o_stat       (b_stat),
    .o_overrun    ()
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (failures == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Reset held for ten cycles, inputs change on falling edges
  task automatic do_reset();
    @(negedge i_clk);
    i_rst = 1'b1;
    repeat (10) @(negedge i_clk);
    i_rst = 1'b0;
  endtask

  // Counts strobes and words over 16 cycles and checks word contents
  task automatic run_gear(input logic gear, input logic ddr, input logic [15:0] n,
                          input logic [15:0] nv, input logic [3:0] w);
    int ups;
    int vals;
    ups  = 0;
    vals = 0;
    cfg.gear   = aag_gear_e'(gear);
    cfg.ddr_en = ddr;
    do_reset();
    repeat (12) @(negedge i_clk);
    repeat (16) begin
      @(negedge i_clk);
      if (o_update === 1'b1) ups++;
      if (o_word_valid === 1'b1) begin
        vals++;
        check({12'h000, o_word}, {12'h000, w});
      end
    end
    check(ups[15:0], n);
    check(vals[15:0], nv);
  endtask

  // Lets the aligner find a point on an edge-rich stream, then holds it
  task automatic run_align(input logic [3:0] win);
    int k;
    cfg.dly_mode = AAG_DLY_ADAPTIVE;
    cfg.hold     = 1'b0;
    cfg.win      = win;
    cfg.static_tap = 8'h11;
    pat          = 1'b1;
    do_reset();
    k = 0;
    while (o_stat.locked !== 1'b1 && k < 3000) begin
      @(negedge i_clk);
      k++;
    end
    check({15'h0000, o_stat.locked}, 16'h0001);
    check({15'h0000, o_stat.tap < 8'h90}, 16'h0001);
    check({15'h0000, b_stat.locked}, 16'h0000);
    check({8'h00, b_stat.tap}, {8'h00, cfg.static_tap});
    cfg.hold = 1'b1;
    @(negedge i_clk);
    tap_seen = o_stat.tap;
    repeat (100) @(negedge i_clk);
    check({8'h00, o_stat.tap}, {8'h00, tap_seen});
    check({15'h0000, o_stat.locked}, 16'h0001);
  endtask

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge i_clk);
    failures++;
    results();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    failures        = 0;
    samples_checked = 0;
    i_rst           = 1'b1;
    i_word_ready    = 1'b1;
    pat             = 1'b0;
    lvl             = 2'h2;
    cfg             = '0;
    cfg.win         = WIN_DEFAULT;
    cfg.static_tap  = TAP_LAST;
    cfg.bus_tap     = 8'h47;
    do_reset();
    // Quiet outputs straight after reset
    check({9'h000, o_word, o_word_valid, o_update, o_overrun}, 16'h0000);
    check({7'h00, o_stat}, 16'h0000);
    // Delay source selection, last tap as boundary
    cfg.dly_mode = AAG_DLY_STATIC;
    repeat (2) @(negedge i_clk);
    check({8'h00, o_stat.tap}, 16'h008F);
    cfg.dly_mode = AAG_DLY_BUS;
    repeat (2) @(negedge i_clk);
    check({8'h00, o_stat.tap}, 16'h0047);
    // Gearbox modes: pin high, pair low
    cfg.dly_mode   = AAG_DLY_STATIC;
    cfg.static_tap = 8'h00;
    run_gear(1'b0, 1'b0, 16'd8, 16'd8, 4'h3);
    run_gear(1'b0, 1'b1, 16'd16, 16'd16, 4'h2);
    run_gear(1'b1, 1'b0, 16'd4, 16'd4, 4'hF);
    run_gear(1'b1, 1'b1, 16'd8, 16'd8, 4'hA);
    // Fabric stalls: strobes go on, no word is taken, buffer fills and flags it
    i_word_ready = 1'b0;
    run_gear(1'b0, 1'b0, 16'd8, 16'd0, 4'h3);
    check({15'h0000, o_overrun}, 16'h0001);
    i_word_ready = 1'b1;
    repeat (20) @(negedge i_clk);
    check({15'h0000, o_overrun}, 16'h0001);
    // Adaptive alignment with two window widths
    run_align(WIN_DEFAULT);
    run_align(4'h8);
    results();
  end
endmodule
